// ==== verilog/mac_stats_pkg.sv ====
// Constants, field layouts and carrier types for the MAC statistics and DA filter register bank
// Notes on behaviour
// - Read-only 9-bit field reports complete frames in the transmit FIFO, debug only.
// - Read-only 14-bit field reports valid 16-bit half-words in host transmit FIFO.
// - 32-bit read-only counter counts host frames dropped on transmit FIFO overflow.
// - Either uncorrectable-ECC flag asserting latches the 14-bit error location.
// - Location stays frozen; re-arms only after both uncorrectable flags clear.
// - Location is a word index into the 16-bit-wide packet buffer.
// - Bank of read-only 10-bit corrected-error counters at consecutive word offsets.
// - Counter 0 receive low FIFO, 1 receive high FIFO, 4 host transmit FIFO.
// - Sixteen filter entries, upper words at even offsets stepping by two.
// - Bit 30 enables the entry for port 1 frames; clear means ignored.
// - Bit 19 picks host receive queue: 0 low priority, 1 high priority.
// - Enabled entry with bit 16 set forwards matching frames to the host.
// - Entry with bit 16 clear discards matching frames.
// - Upper word bits 15:0 hold address bits 47:32, read and write.
// - Lower 32 address bits sit at the odd offset just above the upper word.
package mac_stats_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;
    localparam int FILT_ENTRIES = 16;
    localparam int CORR_COUNTERS = 7;
    localparam int MASK_ENTRIES = 2;
    localparam int FRAME_COUNT_W = 9;
    localparam int HALFWORD_W = 14;
    localparam int LOC_W = 14;
    localparam int CORR_W = 10;
    localparam int DROP_W = 32;
    localparam int IRQ_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_TX_FRAME_COUNT = 8'h3f;
    localparam logic [IDX_W-1:0] IDX_TX_HALFWORD = 8'h40;
    localparam logic [IDX_W-1:0] IDX_OVF_DROPS = 8'h41;
    localparam logic [IDX_W-1:0] IDX_UNCORR_LOC = 8'h42;
    localparam logic [IDX_W-1:0] IDX_CORR_FIRST = 8'h43;
    localparam logic [IDX_W-1:0] IDX_CORR_LAST = 8'h49;
    localparam logic [IDX_W-1:0] IDX_FILT_FIRST = 8'h50;
    localparam logic [IDX_W-1:0] IDX_FILT_LAST = 8'h6f;
    localparam logic [IDX_W-1:0] IDX_MASK_FIRST = 8'h70;
    localparam logic [IDX_W-1:0] IDX_MASK_LAST = 8'h73;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h74;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h75;

    // Filter upper word layout
    localparam int BIT_PORT_ENABLE = 30;
    localparam int BIT_RX_PRI = 19;
    localparam int BIT_FORWARD = 16;
    localparam logic [DATA_W-1:0] UPPER_WMASK = 32'hc009ffff;

    // Reset values
    localparam logic [DATA_W-1:0] REG_RST = 32'h0;
    localparam logic [15:0] MASK_UPPER_RST = 16'hffff;
    localparam logic [DATA_W-1:0] MASK_LOWER_RST = 32'hffffffff;
    localparam logic [47:0] FULL_MASK = 48'hffffffffffff;

    // Interrupt status bits
    localparam int IRQ_OVF_DROP = 0;
    localparam int IRQ_UNCORR = 1;
    localparam int IRQ_CORR = 2;
    localparam int IRQ_FILT_DROP = 3;

    // Corrected counter assignment
    localparam int CORR_RX_LO = 0;
    localparam int CORR_RX_HI = 1;
    localparam int CORR_HOST_TX = 4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic port1;
        logic [47:0] da;
    } da_query_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic forward;
        logic high_pri;
        logic [3:0] entry;
    } da_result_s;
endpackage

// ==== verilog/event_counter.sv ====
// Saturating event counter cleared only by reset
`timescale 1ns/1ns
module event_counter #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Event and count
    input wire logic inc,
    output logic [W-1:0] count
);
    logic [W-1:0] count_ff;

    // Holds at all ones so a reader never sees a wrap to a small value
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else if (inc && (count_ff != {W{1'b1}})) begin
            count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign count = count_ff;
endmodule

// ==== verilog/da_entry_match.sv ====
// Compare of one destination address against one filter entry
`timescale 1ns/1ns
module da_entry_match
    import mac_stats_pkg::*;
(
    // Entry contents
    input wire logic [31:0] upper,
    input wire logic [31:0] lower,
    input wire logic [47:0] mask,
    input wire logic complete,
    // Query
    input wire logic port1,
    input wire logic [47:0] da,
    // Result
    output logic hit
);

    logic [47:0] diff;

    assign diff = (da ^ {upper[15:0], lower}) & mask;
    assign hit = complete && port1 && upper[BIT_PORT_ENABLE] && (diff == 48'h0);
endmodule

// ==== verilog/mac_stats_regs.sv ====
// Register bank for transmit FIFO statistics, ECC error reporting and the DA filter table
`timescale 1ns/1ns
module mac_stats_regs
    import mac_stats_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire reg_req_s reg_req,
    output logic [DATA_W-1:0] reg_rdata_ff,
    // Transmit FIFO state
    input wire logic [FRAME_COUNT_W-1:0] tx_frame_count,
    input wire logic [HALFWORD_W-1:0] tx_halfword_level,
    input wire logic host_tx_overflow_drop,
    // ECC events
    input wire logic rx_ecc_err_flag,
    input wire logic tx_ecc_err_flag,
    input wire logic [LOC_W-1:0] ecc_err_word,
    input wire logic [CORR_COUNTERS-1:0] corrected_error_event,
    // Destination address lookup
    input wire da_query_s da_query,
    output da_result_s da_result_ff,
    // Interrupt
    output logic irq_ff
);
    logic [IDX_W-1:0] idx;
    logic aligned;
    logic [IDX_W-1:0] filt_off;
    logic [IDX_W-1:0] mask_off;
    logic in_filt;
    logic in_mask;
    logic [IDX_W-1:0] corr_off;
    logic in_corr;

    logic [FRAME_COUNT_W-1:0] tx_frame_count_ff;
    logic [HALFWORD_W-1:0] tx_halfword_level_ff;
    logic [DROP_W-1:0] host_tx_overflow_drops;
    logic [LOC_W-1:0] uncorrectable_error_location_ff;
    logic loc_armed_ff;
    logic [CORR_W-1:0] corrected_error_count [CORR_COUNTERS];
    logic [31:0] filt_upper_ff [FILT_ENTRIES];
    logic [31:0] filt_lower_ff [FILT_ENTRIES];
    logic [FILT_ENTRIES-1:0] filt_complete_ff;
    logic [15:0] mask_upper_ff [MASK_ENTRIES];
    logic [31:0] mask_lower_ff [MASK_ENTRIES];
    logic [FILT_ENTRIES-1:0] hit_vec;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] irq_events;
    logic [DATA_W-1:0] nxt_rdata;
    logic any_hit;
    logic [3:0] win_entry;
    logic [31:0] win_upper;
    logic uncorr_any;

    // Address decode
    assign idx = reg_req.addr[ADDR_W-1:2];
    assign aligned = (reg_req.addr[1:0] == 2'h0);
    assign filt_off = idx - IDX_FILT_FIRST;
    assign mask_off = idx - IDX_MASK_FIRST;
    assign corr_off = idx - IDX_CORR_FIRST;
    assign in_filt = aligned && (idx >= IDX_FILT_FIRST) && (idx <= IDX_FILT_LAST);
    assign in_mask = aligned && (idx >= IDX_MASK_FIRST) && (idx <= IDX_MASK_LAST);
    assign in_corr = aligned && (idx >= IDX_CORR_FIRST) && (idx <= IDX_CORR_LAST);
    assign uncorr_any = rx_ecc_err_flag || tx_ecc_err_flag;

    // FIFO levels are sampled every cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_frame_count_ff <= '0;
            tx_halfword_level_ff <= '0;
        end else begin
            tx_frame_count_ff <= tx_frame_count;
            tx_halfword_level_ff <= tx_halfword_level;
        end
    end

    event_counter #(.W(DROP_W)) u_drop_count (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inc(host_tx_overflow_drop),
        .count(host_tx_overflow_drops)
    );

    // One counter per buffer FIFO; index 0 rx low, 1 rx high, 4 host tx
    generate
        for (genvar c = 0; c < CORR_COUNTERS; c++) begin : g_corr
            event_counter #(.W(CORR_W)) u_corr_count (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .inc(corrected_error_event[c]),
                .count(corrected_error_count[c])
            );
        end
    endgenerate

    // First uncorrectable error location, a 16-bit word index into the buffer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            uncorrectable_error_location_ff <= '0;
            loc_armed_ff <= 1'b1;
        end else if (loc_armed_ff && uncorr_any) begin
            uncorrectable_error_location_ff <= ecc_err_word;
            loc_armed_ff <= 1'b0;
        end else if (!loc_armed_ff && !uncorr_any) begin
            loc_armed_ff <= 1'b1;
        end
    end

    // Filter table; upper write invalidates the entry until its lower word lands
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int e = 0; e < FILT_ENTRIES; e++) begin
                filt_upper_ff[e] <= REG_RST;
                filt_lower_ff[e] <= REG_RST;
            end
            filt_complete_ff <= '0;
        end else if (reg_req.wr && in_filt) begin
            if (!filt_off[0]) begin
                filt_upper_ff[filt_off[4:1]] <= reg_req.wdata & UPPER_WMASK;
                filt_complete_ff[filt_off[4:1]] <= 1'b0;
            end else begin
                filt_lower_ff[filt_off[4:1]] <= reg_req.wdata;
                filt_complete_ff[filt_off[4:1]] <= 1'b1;
            end
        end
    end

    // Mask table for the first entries; later entries compare every bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < MASK_ENTRIES; m++) begin
                mask_upper_ff[m] <= MASK_UPPER_RST;
                mask_lower_ff[m] <= MASK_LOWER_RST;
            end
        end else if (reg_req.wr && in_mask) begin
            if (!mask_off[0]) begin
                mask_upper_ff[mask_off[1]] <= reg_req.wdata[15:0];
            end else begin
                mask_lower_ff[mask_off[1]] <= reg_req.wdata;
            end
        end
    end

    generate
        for (genvar e = 0; e < FILT_ENTRIES; e++) begin : g_match
            logic [47:0] entry_mask;
            if (e < MASK_ENTRIES) begin : g_masked
                assign entry_mask = {mask_upper_ff[e], mask_lower_ff[e]};
            end else begin : g_full
                assign entry_mask = FULL_MASK;
            end
            da_entry_match u_match (
                .upper(filt_upper_ff[e]),
                .lower(filt_lower_ff[e]),
                .mask(entry_mask),
                .complete(filt_complete_ff[e]),
                .port1(da_query.port1),
                .da(da_query.da),
                .hit(hit_vec[e])
            );
        end
    endgenerate

    // Lowest-numbered hitting entry decides the frame
    always_comb begin
        any_hit = 1'b0;
        win_entry = 4'h0;
        for (int e = FILT_ENTRIES - 1; e >= 0; e--) begin
            if (hit_vec[e]) begin
                any_hit = 1'b1;
                win_entry = e[3:0];
            end
        end
        win_upper = filt_upper_ff[win_entry];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            da_result_ff <= '0;
        end else begin
            da_result_ff.valid <= da_query.valid;
            da_result_ff.hit <= da_query.valid && any_hit;
            da_result_ff.forward <= da_query.valid && any_hit && win_upper[BIT_FORWARD];
            da_result_ff.high_pri <= da_query.valid && any_hit && win_upper[BIT_RX_PRI];
            da_result_ff.entry <= win_entry;
        end
    end

    // Interrupt status: set wins over a write-one clear in the same cycle
    assign irq_events[IRQ_OVF_DROP] = host_tx_overflow_drop;
    assign irq_events[IRQ_UNCORR] = loc_armed_ff && uncorr_any;
    assign irq_events[IRQ_CORR] = |corrected_error_event;
    assign irq_events[IRQ_FILT_DROP] = da_query.valid && any_hit && !win_upper[BIT_FORWARD];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_ff <= '0;
        end else if (reg_req.wr && aligned && (idx == IDX_IRQ_STATUS)) begin
            irq_status_ff <= (irq_status_ff & ~reg_req.wdata[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status_ff <= irq_status_ff | irq_events;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_ff <= '0;
        end else if (reg_req.wr && aligned && (idx == IDX_IRQ_MASK)) begin
            irq_mask_ff <= reg_req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // Read mux; read-only fields have no write path, unmapped reads return zero
    always_comb begin
        nxt_rdata = REG_RST;
        if (!aligned) begin
            nxt_rdata = REG_RST;
        end else if (idx == IDX_TX_FRAME_COUNT) begin
            nxt_rdata = {{(DATA_W-FRAME_COUNT_W){1'b0}}, tx_frame_count_ff};
        end else if (idx == IDX_TX_HALFWORD) begin
            nxt_rdata = {{(DATA_W-HALFWORD_W){1'b0}}, tx_halfword_level_ff};
        end else if (idx == IDX_OVF_DROPS) begin
            nxt_rdata = host_tx_overflow_drops;
        end else if (idx == IDX_UNCORR_LOC) begin
            nxt_rdata = {{(DATA_W-LOC_W){1'b0}}, uncorrectable_error_location_ff};
        end else if (in_corr) begin
            nxt_rdata = {{(DATA_W-CORR_W){1'b0}}, corrected_error_count[corr_off[2:0]]};
        end else if (in_filt) begin
            nxt_rdata = filt_off[0] ? filt_lower_ff[filt_off[4:1]] : filt_upper_ff[filt_off[4:1]];
        end else if (in_mask) begin
            nxt_rdata = mask_off[0] ? mask_lower_ff[mask_off[1]] : {16'h0, mask_upper_ff[mask_off[1]]};
        end else if (idx == IDX_IRQ_STATUS) begin
            nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status_ff};
        end else if (idx == IDX_IRQ_MASK) begin
            nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_ff};
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= REG_RST;
        end else begin
            reg_rdata_ff <= reg_req.rd ? nxt_rdata : REG_RST;
        end
    end

    property p_frame_count_follows;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_req.rd && aligned && (idx == IDX_TX_FRAME_COUNT) ##0 (tx_frame_count_ff == $past(tx_frame_count))
            |=> reg_rdata_ff == {23'h0, $past(tx_frame_count_ff)};
    endproperty
    a_frame_count_follows: assert property (p_frame_count_follows) else $error("frame count readback wrong");

    property p_halfword_follows;
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n |=> tx_halfword_level_ff == $past(tx_halfword_level);
    endproperty
    a_halfword_follows: assert property (p_halfword_follows) else $error("half-word level not sampled");

    property p_drop_counts;
        @(posedge sys_clk) disable iff (!rst_n)
        host_tx_overflow_drop && (host_tx_overflow_drops != 32'hffffffff)
            |=> host_tx_overflow_drops == $past(host_tx_overflow_drops) + 32'h1;
    endproperty
    a_drop_counts: assert property (p_drop_counts) else $error("overflow drop not counted");

    property p_drop_ro;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_req.wr && !host_tx_overflow_drop |=> $stable(host_tx_overflow_drops);
    endproperty
    a_drop_ro: assert property (p_drop_ro) else $error("write changed a read-only counter");

    property p_loc_capture;
        @(posedge sys_clk) disable iff (!rst_n)
        loc_armed_ff && uncorr_any |=> (uncorrectable_error_location_ff == $past(ecc_err_word)) && !loc_armed_ff;
    endproperty
    a_loc_capture: assert property (p_loc_capture) else $error("error location not captured");

    property p_loc_frozen;
        @(posedge sys_clk) disable iff (!rst_n)
        !loc_armed_ff && uncorr_any |=> $stable(uncorrectable_error_location_ff) && !loc_armed_ff;
    endproperty
    a_loc_frozen: assert property (p_loc_frozen) else $error("error location not frozen");

    property p_host_tx_corr;
        @(posedge sys_clk) disable iff (!rst_n)
        corrected_error_event[CORR_HOST_TX] && (corrected_error_count[CORR_HOST_TX] != 10'h3ff)
            |=> corrected_error_count[CORR_HOST_TX] == $past(corrected_error_count[CORR_HOST_TX]) + 10'h1;
    endproperty
    a_host_tx_corr: assert property (p_host_tx_corr) else $error("host tx corrected count missed");

    property p_disabled_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        !filt_upper_ff[0][BIT_PORT_ENABLE] |-> !hit_vec[0];
    endproperty
    a_disabled_entry: assert property (p_disabled_entry) else $error("disabled entry matched");

    property p_forward_rule;
        @(posedge sys_clk) disable iff (!rst_n)
        da_query.valid && any_hit
            |=> da_result_ff.hit && (da_result_ff.forward == $past(win_upper[BIT_FORWARD]))
                && (da_result_ff.high_pri == $past(win_upper[BIT_RX_PRI]));
    endproperty
    a_forward_rule: assert property (p_forward_rule) else $error("forwarding decision wrong");

    property p_irq_level;
        @(posedge sys_clk) disable iff (!rst_n)
        (irq_status_ff & irq_mask_ff) != 4'h0 |=> irq_ff;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    property p_irq_set_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_req.wr && aligned && (idx == IDX_IRQ_STATUS)
            |=> (irq_status_ff & $past(irq_events)) == $past(irq_events);
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost to a status clear");

    property p_loc_rearm;
        @(posedge sys_clk) disable iff (!rst_n)
        !loc_armed_ff && !uncorr_any |=> loc_armed_ff;
    endproperty
    a_loc_rearm: assert property (p_loc_rearm) else $error("capture not re-armed");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_req.rd |=> reg_rdata_ff == REG_RST;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    c_loc_capture: cover property (@(posedge sys_clk) disable iff (!rst_n) loc_armed_ff && uncorr_any);
    c_forward: cover property (@(posedge sys_clk) disable iff (!rst_n) da_result_ff.hit && da_result_ff.forward);
    c_filter_drop: cover property (@(posedge sys_clk) disable iff (!rst_n) da_result_ff.hit && !da_result_ff.forward);
    c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_ff);
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the MAC statistics and DA filter register bank
`timescale 1ns/1ns
module testbench;
    import mac_stats_pkg::*;
    logic sys_clk;
    logic rst_n;
    reg_req_s reg_req;
    logic [DATA_W-1:0] reg_rdata_ff;
    logic [FRAME_COUNT_W-1:0] tx_frame_count;
    logic [HALFWORD_W-1:0] tx_halfword_level;
    logic host_tx_overflow_drop;
    logic rx_ecc_err_flag;
    logic tx_ecc_err_flag;
    logic [LOC_W-1:0] ecc_err_word;
    logic [CORR_COUNTERS-1:0] corrected_error_event;
    da_query_s da_query;
    da_result_s da_result_ff;
    logic irq_ff;
    int error_cnt;
    int checks_done;

    mac_stats_regs u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
        .tx_frame_count(tx_frame_count), .tx_halfword_level(tx_halfword_level),
        .host_tx_overflow_drop(host_tx_overflow_drop), .rx_ecc_err_flag(rx_ecc_err_flag),
        .tx_ecc_err_flag(tx_ecc_err_flag), .ecc_err_word(ecc_err_word),
        .corrected_error_event(corrected_error_event), .da_query(da_query),
        .da_result_ff(da_result_ff), .irq_ff(irq_ff)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [ADDR_W-1:0] bya(input int idx);
        return ADDR_W'(idx * 4);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input int idx, input logic [31:0] data);
        @(posedge sys_clk);
        reg_req.wr <= 1'b1;
        reg_req.addr <= bya(idx);
        reg_req.wdata <= data;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input int idx, input logic [31:0] exp, input string what);
        @(posedge sys_clk);
        reg_req.rd <= 1'b1;
        reg_req.addr <= bya(idx);
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata_ff);
    endtask

    task automatic query(input logic port1, input logic [47:0] da, input logic [7:0] exp);
        @(posedge sys_clk);
        da_query <= {1'b1, port1, da};
        @(posedge sys_clk);
        da_query.valid <= 1'b0;
        #1;
        check("da_result", {24'h0, exp}, {24'h0, da_result_ff});
    endtask

    task automatic test_reset();
        for (int i = 8'h3f; i <= 8'h49; i++) reg_rd(i, 32'h0, "status reset");
        reg_rd(IDX_FILT_FIRST, 32'h0, "filter upper reset");
        reg_rd(IDX_FILT_FIRST + 1, 32'h0, "filter lower reset");
        reg_rd(IDX_MASK_FIRST, 32'h0000ffff, "mask upper reset");
        reg_rd(IDX_MASK_FIRST + 1, 32'hffffffff, "mask lower reset");
        reg_rd(8'h7f, 32'h0, "unmapped read");
        check("irq reset", 32'h0, {31'h0, irq_ff});
        $display("test reset done");
    endtask

    task automatic test_levels();
        @(posedge sys_clk);
        tx_frame_count <= 9'h155;
        tx_halfword_level <= 14'h2abc;
        reg_wr(IDX_TX_FRAME_COUNT, 32'hffffffff);
        reg_wr(IDX_TX_HALFWORD, 32'hffffffff);
        reg_rd(IDX_TX_FRAME_COUNT, 32'h155, "frame count");
        reg_rd(IDX_TX_HALFWORD, 32'h2abc, "halfword level");
        @(posedge sys_clk);
        tx_frame_count <= 9'h0aa;
        tx_halfword_level <= 14'h1543;
        repeat (2) @(posedge sys_clk);
        reg_rd(IDX_TX_FRAME_COUNT, 32'h0aa, "frame count");
        reg_rd(IDX_TX_HALFWORD, 32'h1543, "halfword level");
        $display("test levels done");
    endtask

    task automatic test_drops();
        reg_wr(IDX_OVF_DROPS, 32'hffffffff);
        reg_rd(IDX_OVF_DROPS, 32'h0, "drop count written");
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            host_tx_overflow_drop <= 1'b1;
            @(posedge sys_clk);
            host_tx_overflow_drop <= 1'b0;
        end
        reg_rd(IDX_OVF_DROPS, 32'h3, "drop count");
        check("irq masked", 32'h0, {31'h0, irq_ff});
        reg_wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq raised", 32'h1, {31'h0, irq_ff});
        reg_wr(IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq cleared", 32'h0, {31'h0, irq_ff});
        reg_wr(IDX_IRQ_MASK, 32'h0);
        $display("test drops done");
    endtask

    task automatic test_ecc();
        ecc_err_word <= 14'h2a5a;
        rx_ecc_err_flag <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ecc_err_word <= 14'h1111;
        tx_ecc_err_flag <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rx_ecc_err_flag <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reg_wr(IDX_UNCORR_LOC, 32'h0);
        reg_rd(IDX_UNCORR_LOC, 32'h2a5a, "error location frozen");
        @(posedge sys_clk);
        tx_ecc_err_flag <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ecc_err_word <= 14'h0123;
        tx_ecc_err_flag <= 1'b1;
        repeat (3) @(posedge sys_clk);
        tx_ecc_err_flag <= 1'b0;
        reg_rd(IDX_UNCORR_LOC, 32'h0123, "error location rearmed");
        $display("test ecc done");
    endtask

    task automatic test_corr();
        for (int n = 0; n < CORR_COUNTERS; n++) begin
            for (int k = 0; k <= n; k++) begin
                @(posedge sys_clk);
                corrected_error_event <= CORR_COUNTERS'(1 << n);
                @(posedge sys_clk);
                corrected_error_event <= '0;
            end
        end
        repeat (2) @(posedge sys_clk);
        for (int n = 0; n < CORR_COUNTERS; n++) reg_rd(IDX_CORR_FIRST + n, n + 1, "corrected count");
        $display("test corrected done");
    endtask

    task automatic test_filter();
        reg_wr(IDX_FILT_FIRST + 4, 32'hffff1234);
        reg_wr(IDX_FILT_FIRST + 5, 32'h56789abc);
        reg_rd(IDX_FILT_FIRST + 4, 32'hc0091234, "entry 2 upper");
        reg_rd(IDX_FILT_FIRST + 5, 32'h56789abc, "entry 2 lower");
        query(1'b1, 48'h123456789abc, 8'hf2);
        query(1'b0, 48'h123456789abc, 8'h80);
        query(1'b1, 48'h123456789abd, 8'h80);
        reg_wr(IDX_FILT_FIRST + 10, 32'h400000aa);
        reg_wr(IDX_FILT_FIRST + 11, 32'h00000001);
        query(1'b1, 48'h00aa00000001, 8'hc5);
        reg_wr(IDX_FILT_FIRST + 12, 32'h000100bb);
        reg_wr(IDX_FILT_FIRST + 13, 32'h00000001);
        query(1'b1, 48'h00bb00000001, 8'h80);
        reg_wr(IDX_FILT_FIRST + 14, 32'h400100cc);
        query(1'b1, 48'h00cc00000000, 8'h80);
        reg_wr(IDX_FILT_FIRST + 15, 32'h00000000);
        query(1'b1, 48'h00cc00000000, 8'he7);
        reg_wr(IDX_FILT_FIRST + 30, 32'h400100dd);
        reg_wr(IDX_FILT_FIRST + 31, 32'h00000002);
        query(1'b1, 48'h00dd00000002, 8'hef);
        reg_wr(IDX_FILT_FIRST, 32'h40010011);
        reg_wr(IDX_FILT_FIRST + 1, 32'h22222200);
        reg_wr(IDX_MASK_FIRST, 32'h0000ffff);
        reg_wr(IDX_MASK_FIRST + 1, 32'hffffff00);
        query(1'b1, 48'h0011222222ee, 8'he0);
        // Uncorrectable capture, corrected event and filter drop are pending; overflow was cleared
        reg_rd(IDX_IRQ_STATUS, 32'he, "irq status");
        $display("test filter done");
    endtask

    task automatic test_mid_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_rd(IDX_OVF_DROPS, 32'h0, "drop count after reset");
        reg_rd(IDX_CORR_FIRST + CORR_HOST_TX, 32'h0, "corrected count after reset");
        reg_rd(IDX_UNCORR_LOC, 32'h0, "location after reset");
        reg_rd(IDX_IRQ_STATUS, 32'h0, "irq status after reset");
        $display("test mid reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_n = 1'b0;
        reg_req = '0;
        tx_frame_count = '0;
        tx_halfword_level = '0;
        host_tx_overflow_drop = 1'b0;
        rx_ecc_err_flag = 1'b0;
        tx_ecc_err_flag = 1'b0;
        ecc_err_word = '0;
        corrected_error_event = '0;
        da_query = '0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_reset();
        test_levels();
        test_drops();
        test_ecc();
        test_corr();
        test_filter();
        test_mid_reset();
        tally_and_finish();
    end
endmodule
